// ### verilog/fcl_pkg.sv
/*
 * shared constants and carrier types of the configuration image loader:
 * flash map, image layout, spi command, timing figures and state names.
 * assumes a single system clock derived from the board oscillator.
 */
package fcl_pkg;

  // ***************************************************************
  // clocking
  // ***************************************************************
  localparam int OSC_HZ = 50_000_000;
  localparam int OSC_DIV = 2;
  localparam int SYS_CLK_HZ = OSC_HZ / OSC_DIV;  // RQ17
  localparam int PHY_CLK_HZ = 25_000_000;        // RQ17

  // ***************************************************************
  // flash map
  // ***************************************************************
  localparam int FLASH_BITS = 16 * 1024 * 1024;
  localparam int SECTOR_BYTES = 64 * 1024;
  localparam int SECTOR_COUNT = 32;
  localparam int IMAGE_SECTORS = 11;
  localparam logic [23:0] FALLBACK_BASE = 24'h000000;
  localparam logic [23:0] USER_BASE = 24'h100000;
  localparam logic [23:0] USER_LAST_BLOCK = 24'h1a0000;
  localparam logic [23:0] FREE_FIRST = 24'h1b0000;
  localparam logic [23:0] APP_DATA_FIRST = 24'h1d0000;
  localparam logic [23:0] APP_DATA_LAST = 24'h1f0000;
  localparam logic [23:0] IMAGE_MAX_BYTES = 24'(IMAGE_SECTORS * SECTOR_BYTES);

  // ***************************************************************
  // image stream: 3 length bytes, payload, 2 crc bytes
  // ***************************************************************
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [23:0] HDR_BYTES = 24'h000003;
  localparam logic [23:0] TRAILER_LAST = 24'h000004;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [31:0] FIXED_IP = 32'hc0a80179;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int SPI_HALF_CYC = 4;
  localparam logic [2:0] STRAP_WAIT_CYC = 3'h4;
  localparam int LOAD_LIMIT_MS = 900;
  localparam int LOAD_LIMIT_CYC = (SYS_CLK_HZ / 1000) * LOAD_LIMIT_MS;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = (SYS_CLK_HZ / 1000) * BLINK_MS;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [2:0] {
    ST_STRAP, ST_OPEN, ST_CMD, ST_READ, ST_CHECK, ST_RUN, ST_FAIL
  } fcl_state_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fcl_cfg_type;

  typedef struct packed {
    logic cs;
    logic go;
    logic [7:0] tx;
  } fcl_host_req_type;

  typedef struct packed {
    logic ready;
    logic done;
    logic [7:0] rx;
  } fcl_host_rsp_type;

endpackage : fcl_pkg

// ### verilog/fcl_spi_byte.sv
/*
 * spi mode 0 byte engine: shifts one byte out and one in, msb first.
 * assumes start only while busy is low; miso comes from a pin.
 */
`timescale 1ns/100ps
module fcl_spi_byte #(
  parameter int HALF = fcl_pkg::SPI_HALF_CYC
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [7:0] tx_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic mosi_o,
  output logic [7:0] rx_o,
  output logic done_o,
  output logic busy_o
);
  import fcl_pkg::*;

  logic miso_meta;
  logic miso_s;
  logic [3:0] div;
  logic [2:0] bit_cnt;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  wire phase_end = busy_o && (div == 4'(HALF - 1));

  // two-stage pin synchroniser
  always_ff @(posedge clk_sys_i) begin
    miso_meta <= nrst_i ? miso_i : 1'b0;
    miso_s <= nrst_i ? miso_meta : 1'b0;
  end

  // sampling at the end of the high phase hides the synchroniser lag
  always_ff @(posedge clk_sys_i) begin
    done_o <= 1'b0;
    if (!nrst_i) begin
      busy_o <= 1'b0;
      sclk_o <= 1'b0;
      mosi_o <= 1'b0;
      div <= 4'h0;
      bit_cnt <= 3'h0;
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      rx_o <= 8'h00;
    end else if (start_i && !busy_o) begin
      busy_o <= 1'b1;
      tx_sh <= tx_i;
      mosi_o <= tx_i[7];
      div <= 4'h0;
      bit_cnt <= 3'h0;
    end else if (busy_o) begin
      div <= phase_end ? 4'h0 : div + 4'h1;
      if (phase_end && !sclk_o) begin
        sclk_o <= 1'b1;
      end else if (phase_end) begin
        sclk_o <= 1'b0;
        rx_sh <= {rx_sh[6:0], miso_s};
        bit_cnt <= bit_cnt + 3'h1;
        tx_sh <= {tx_sh[6:0], 1'b0};
        mosi_o <= tx_sh[6];
        if (bit_cnt == 3'h7) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          rx_o <= {rx_sh[6:0], miso_s};
        end
      end
    end
  end
endmodule : fcl_spi_byte

// ### verilog/fcl_crc.sv
/*
 * byte-wide crc-16 accumulator, non-reflected, no final inversion.
 * feeding a message followed by its own crc leaves a zero residue.
 */
`timescale 1ns/100ps
module fcl_crc (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [7:0] byte_i,
  output logic [15:0] crc_o
);
  import fcl_pkg::*;

  logic [15:0] next_crc;

  // one byte per clock, unrolled over the eight message bits
  always_comb begin
    next_crc = crc_o;
    for (int i = 7; i >= 0; i--) begin
      if (next_crc[15] ^ byte_i[i]) begin
        next_crc = {next_crc[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        next_crc = {next_crc[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || clr_i) begin
      crc_o <= CRC_INIT;
    end else if (en_i) begin
      crc_o <= next_crc;
    end
  end
endmodule : fcl_crc

// ### verilog/fcl_loader.sv
/*
 * configuration image loader: reads a user or fallback image from one of
 * two spi flashes, streams it into the fabric, checks its crc, then lends
 * the spi path to the host for flash rewrite and reload.
 * assumes flash pins and jumpers are asynchronous; host port is on clk.
 */
//
// Behaviour
// RQ1: power up loads image from 16M flash
// RQ2: corrupt user image falls back to fallback
// RQ3: only a failed load invokes fallback; code also enters it when both ip jumpers are up
// RQ4: flash is 32 sectors of 64K
// RQ5: user image at 0x100000, eleven blocks
// RQ6: host keeps data in last three sectors
// RQ7: fallback image has own eleven blocks
// RQ8: fallback running blinks red init lamp
// RQ9: both ip jumpers up force fallback
// RQ10: done lamp stays lit on failure
// RQ11: load finishes within a fraction second
// RQ12: jumper picks boot flash at power up
// RQ13: running image offers host spi path
// RQ14: host reload restarts from user region
// RQ15: host never swaps image regions
// RQ16: operator restores primary flash before rewrite
// RQ17: one oscillator derives all clocks
// RQ18: crc checked before starting user logic
`timescale 1ns/100ps
module fcl_loader #(
  parameter logic [24:0] LOAD_LIMIT = 25'(fcl_pkg::LOAD_LIMIT_CYC),
  parameter logic [24:0] BLINK_HALF = 25'(fcl_pkg::BLINK_CYC)
) (
  input wire logic clk_sys_i,  // RQ17
  input wire logic nrst_i,
  input wire logic flash_chip_select_jumper_i,
  input wire logic flash_chip_select_jumper_alt_i,
  input wire logic ip_select_jumper_a_i,
  input wire logic ip_select_jumper_b_i,
  input wire logic flash_miso_i,
  output logic flash_sclk_o,
  output logic flash_mosi_o,
  output logic [1:0] flash_cs_n_o,
  output fcl_pkg::fcl_cfg_type cfg_o,
  output logic logic_run_o,
  output logic fallback_active_o,
  output logic init_lamp_o,
  output logic config_done_lamp_n_o,
  output logic ip_fixed_o,
  output logic [31:0] ip_fixed_addr_o,
  input wire fcl_pkg::fcl_host_req_type host_req_i,
  input wire logic host_reload_i,
  output fcl_pkg::fcl_host_rsp_type host_rsp_o
);
  import fcl_pkg::*;

  // ***************************************************************
  // state and registers
  // ***************************************************************
  fcl_state_type state;
  logic [3:0] jmp_meta;
  logic [3:0] jmp_s;
  logic [2:0] strap_cnt;
  logic chip_backup;
  logic force_fb;
  logic using_fb;
  logic [1:0] idx;
  logic [23:0] rd_cnt;
  logic [23:0] img_len;
  logic [24:0] load_timer;
  logic [24:0] blink_cnt;
  logic ld_go;
  logic [7:0] ld_tx;
  logic spi_done;
  logic spi_busy;
  logic [7:0] spi_rx;
  logic [15:0] crc;

  // ***************************************************************
  // decode
  // ***************************************************************
  wire loading = (state == ST_OPEN) || (state == ST_CMD) || (state == ST_READ);
  wire running = (state == ST_RUN);
  wire [23:0] base = using_fb ? FALLBACK_BASE : USER_BASE;  // RQ5 RQ7
  wire [31:0] cmd_word = {READ_CMD, base};
  wire [23:0] new_len = {img_len[15:0], spi_rx};
  wire len_bad = (new_len == 24'h0) || (new_len > IMAGE_MAX_BYTES);  // RQ4 RQ7
  wire in_hdr = rd_cnt < HDR_BYTES;
  wire in_payload = !in_hdr && (rd_cnt < img_len + HDR_BYTES);
  wire last_byte = (rd_cnt == img_len + TRAILER_LAST);
  wire timed_out = loading && (state != ST_OPEN) && (load_timer == LOAD_LIMIT);  // RQ11
  wire hdr_fail = (state == ST_READ) && spi_done && (rd_cnt == 24'h2) && len_bad;
  wire crc_bad = (state == ST_CHECK) && (crc != 16'h0000);  // RQ18
  wire img_fail = timed_out || hdr_fail || crc_bad;
  wire host_take = running && host_req_i.go && !spi_busy;  // RQ13
  wire spi_start = running ? host_take : ld_go;
  wire [7:0] spi_tx = running ? host_req_i.tx : ld_tx;
  wire cs_active = (state == ST_CMD) || (state == ST_READ) || (running && host_req_i.cs);
  wire [1:0] chip_mask = chip_backup ? 2'b10 : 2'b01;  // RQ12
  wire strap_done = (state == ST_STRAP) && (strap_cnt == STRAP_WAIT_CYC);
  wire jmp_backup = !jmp_s[0] || !jmp_s[1];
  wire jmp_force = jmp_s[2] && jmp_s[3];
  wire blink_wrap = (blink_cnt == BLINK_HALF);

  // ***************************************************************
  // submodules
  // ***************************************************************
  fcl_spi_byte u_spi (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .start_i(spi_start),
    .tx_i(spi_tx),
    .miso_i(flash_miso_i),
    .sclk_o(flash_sclk_o),
    .mosi_o(flash_mosi_o),
    .rx_o(spi_rx),
    .done_o(spi_done),
    .busy_o(spi_busy)
  );

  fcl_crc u_crc (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .clr_i(state == ST_OPEN),
    .en_i((state == ST_READ) && spi_done),
    .byte_i(spi_rx),
    .crc_o(crc)
  );

  // jumper synchronisers; levels are only used once the straps settle
  always_ff @(posedge clk_sys_i) begin
    jmp_meta <= nrst_i ? {ip_select_jumper_b_i, ip_select_jumper_a_i,
                          flash_chip_select_jumper_alt_i, flash_chip_select_jumper_i} : 4'h0;
    jmp_s <= nrst_i ? jmp_meta : 4'h0;
  end

  // ***************************************************************
  // load sequencer
  // ***************************************************************
  // a reset is the only way to re-read the straps
  always_ff @(posedge clk_sys_i) begin
    ld_go <= 1'b0;
    if (!nrst_i) begin
      state <= ST_STRAP;
      strap_cnt <= 3'h0;
      chip_backup <= 1'b0;
      force_fb <= 1'b0;
      using_fb <= 1'b0;
      idx <= 2'h0;
      rd_cnt <= 24'h0;
      img_len <= 24'h0;
      ld_tx <= 8'h00;
    end else begin
      case (state)
        ST_STRAP: begin
          strap_cnt <= strap_cnt + 3'h1;
          if (strap_done) begin
            chip_backup <= jmp_backup;  // RQ12
            force_fb <= jmp_force;
            using_fb <= jmp_force;  // RQ9
            state <= ST_OPEN;
          end
        end
        ST_OPEN: begin
          idx <= 2'h0;
          rd_cnt <= 24'h0;
          img_len <= 24'h0;
          ld_tx <= cmd_word[31:24];  // RQ1
          if (!spi_busy) begin  // a byte cut by a failed attempt drains first
            ld_go <= 1'b1;
            state <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (timed_out) begin
            state <= using_fb ? ST_FAIL : ST_OPEN;
            using_fb <= 1'b1;
          end else if (spi_done) begin
            idx <= idx + 2'h1;
            ld_go <= 1'b1;
            ld_tx <= (idx == 2'h3) ? 8'h00 : cmd_word[8'(23 - 8 * idx) -: 8];
            if (idx == 2'h3) begin
              state <= ST_READ;
            end
          end
        end
        ST_READ: begin
          if (img_fail) begin
            state <= using_fb ? ST_FAIL : ST_OPEN;  // RQ2
            using_fb <= 1'b1;
          end else if (spi_done) begin
            rd_cnt <= rd_cnt + 24'h1;
            if (in_hdr) begin
              img_len <= new_len;
            end
            if (last_byte) begin
              state <= ST_CHECK;
            end else begin
              ld_go <= 1'b1;
            end
          end
        end
        ST_CHECK: begin
          if (crc_bad) begin
            state <= using_fb ? ST_FAIL : ST_OPEN;  // RQ2 RQ18
            using_fb <= 1'b1;
          end else begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          // a running image never falls back on its own
          if (host_reload_i) begin
            using_fb <= 1'b0;  // RQ3 RQ14
            state <= ST_OPEN;
          end
        end
        ST_FAIL: begin
          state <= ST_FAIL;  // RQ10
        end
        default: begin
          state <= ST_STRAP;
        end
      endcase
    end
  end

  // load watchdog and fallback blink timebase
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || !loading || (state == ST_OPEN)) begin
      load_timer <= 25'h0;
    end else if (!timed_out) begin
      load_timer <= load_timer + 25'h1;
    end
    if (!nrst_i || !(running && using_fb) || blink_wrap) begin
      blink_cnt <= 25'h0;
    end else begin
      blink_cnt <= blink_cnt + 25'h1;
    end
  end

  // ***************************************************************
  // outputs, all registered
  // ***************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      flash_cs_n_o <= 2'b11;
      cfg_o <= '0;
      logic_run_o <= 1'b0;
      fallback_active_o <= 1'b0;
      init_lamp_o <= 1'b0;
      config_done_lamp_n_o <= 1'b0;
      ip_fixed_o <= 1'b0;
      ip_fixed_addr_o <= 32'h0;
      host_rsp_o <= '0;
    end else begin
      flash_cs_n_o <= ~({2{cs_active}} & chip_mask);
      cfg_o.valid <= (state == ST_READ) && spi_done && in_payload && !img_fail;
      cfg_o.data <= spi_rx;
      logic_run_o <= running;  // RQ18
      fallback_active_o <= running && using_fb;
      if (!(running && using_fb)) begin
        init_lamp_o <= 1'b0;
      end else if (blink_wrap) begin
        init_lamp_o <= !init_lamp_o;  // RQ8
      end
      config_done_lamp_n_o <= running;  // RQ10
      ip_fixed_o <= force_fb;  // RQ9
      ip_fixed_addr_o <= force_fb ? FIXED_IP : 32'h0;
      host_rsp_o.ready <= running && !spi_busy && !spi_start;
      host_rsp_o.done <= running && spi_done;  // RQ13
      host_rsp_o.rx <= spi_rx;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  localparam int HOST_MIN = 64;
  localparam int HOST_MAX = 68;

  property p_one_chip;
    @(posedge clk_sys_i) disable iff (!nrst_i) flash_cs_n_o != 2'b00;
  endproperty
  a_one_chip: assert property (p_one_chip) else $error("both flash selects low"); // RQ12

  property p_run_after_check;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      $rose(logic_run_o) |-> $past(state, 2) == ST_CHECK && crc == 16'h0000;
  endproperty
  a_run_after_check: assert property (p_run_after_check) else $error("run without crc"); // RQ18

  property p_fallback_on_bad;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (crc_bad && !using_fb) |=> (state == ST_OPEN) && using_fb ##1 state == ST_CMD;
  endproperty
  a_fallback_on_bad: assert property (p_fallback_on_bad) else $error("no fallback"); // RQ2

  property p_run_stays;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (running && !host_reload_i) |=> running && $stable(using_fb);
  endproperty
  a_run_stays: assert property (p_run_stays) else $error("running image left"); // RQ3

  property p_blink;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (running && using_fb && blink_wrap) |=> init_lamp_o != $past(init_lamp_o);
  endproperty
  a_blink: assert property (p_blink) else $error("init lamp not toggled"); // RQ8

  property p_fail_lamp;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (state == ST_FAIL) |=> ((state == ST_FAIL) && !config_done_lamp_n_o) [*3];
  endproperty
  a_fail_lamp: assert property (p_fail_lamp) else $error("done lamp off on fail"); // RQ10

  property p_forced;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (strap_done && jmp_force) |=> using_fb ##1 ip_fixed_o && ip_fixed_addr_o == FIXED_IP;
  endproperty
  a_forced: assert property (p_forced) else $error("forced fallback ignored"); // RQ9

  property p_timer;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      timed_out |=> !loading || state == ST_OPEN;
  endproperty
  a_timer: assert property (p_timer) else $error("load overran limit"); // RQ11

  property p_reload;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (running && host_reload_i && !spi_busy && !spi_start) |=> state == ST_OPEN && !using_fb
      ##2 !flash_cs_n_o[chip_backup];
  endproperty
  a_reload: assert property (p_reload) else $error("reload not from user region"); // RQ14

  property p_len_ok;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      running |-> img_len != 24'h0 && img_len <= IMAGE_MAX_BYTES;
  endproperty
  a_len_ok: assert property (p_len_ok) else $error("image outside its region"); // RQ5 RQ7

  property p_host_byte;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      host_take |-> ##[HOST_MIN:HOST_MAX] host_rsp_o.done;
  endproperty
  a_host_byte: assert property (p_host_byte) else $error("host byte lost"); // RQ13

  c_user_run: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) running && !using_fb);
  c_fb_run: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) running && using_fb);
  c_fail: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) state == ST_FAIL);
  c_host: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) host_rsp_o.done);
endmodule : fcl_loader

// ### tb/fcl_flash_model.sv
/*
 * behavioural spi serial flash answering the standard read command.
 * assumes mode 0 timing and a memory image filled by the testbench.
 */
`timescale 1ns/100ps
module fcl_flash_model
  import fcl_pkg::*;
(
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o
);
  // ***************************************************************
  // sparse byte array, erased locations read as ff
  // ***************************************************************
  logic [7:0] mem [int];
  logic [31:0] hdr;
  logic [7:0] cur;
  logic drv;
  int nbit;
  int ofs;

  initial begin
    miso_o = 1'b0;
    drv = 1'b0;
    nbit = 0;
    hdr = 32'h0;
  end

  // command and address shift in on rising sclk
  always @(posedge sclk_i) begin
    if (!cs_n_i) begin
      if (nbit < 32) hdr = {hdr[30:0], mosi_i};
      nbit = nbit + 1;
    end
  end

  // read data leaves on falling sclk; one flat byte map, sector blind
  always @(negedge sclk_i) begin
    if (!cs_n_i && nbit >= 32 && hdr[31:24] == READ_CMD) begin
      ofs = (nbit - 32) / 8;
      cur = mem.exists(int'(hdr[23:0] + 24'(ofs))) ? mem[int'(hdr[23:0] + 24'(ofs))] : 8'hff;
      drv = 1'b1;
      miso_o = cur[7 - ((nbit - 32) % 8)];
    end
  end

  // deselect ends the command
  always @(posedge cs_n_i) begin
    nbit = 0;
    drv = 1'b0;
  end

  // an undriven line wanders so a stale bit is never mistaken for data
  always #37 if (!drv) miso_o = ~miso_o;
endmodule : fcl_flash_model

// ### tb/tb_top.sv
/*
 * self-checking bench of the image loader with two flash models.
 * assumes short load and blink counts set through the parameters.
 */
`timescale 1ns/100ps
module tb_top;
  import fcl_pkg::*;
  // ***************************************************************
  // signals and design
  // ***************************************************************
  localparam int PL_N = 4;
  logic clk_sys_i = 1'b0;
  logic nrst_i;
  logic cj, aj, ipa, ipb, reload;
  logic sclk, mosi, miso, m0, m1, run, fb, lamp, done_n, ipf;
  logic [1:0] cs_n;
  logic [31:0] ip_addr;
  fcl_cfg_type cfg;
  fcl_host_req_type hreq;
  fcl_host_rsp_type hrsp;
  logic [7:0] cfg_q [$];
  int n_fail = 0;
  int checks_done = 0;

  always #20 clk_sys_i = ~clk_sys_i;
  // one shared data-out pin, the deselected chip shows noise
  assign miso = cs_n[0] ? m1 : m0;

  fcl_loader #(.LOAD_LIMIT(25'd20000), .BLINK_HALF(25'd50)) fcl_loader_i (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .flash_chip_select_jumper_i(cj), .flash_chip_select_jumper_alt_i(aj),
    .ip_select_jumper_a_i(ipa), .ip_select_jumper_b_i(ipb),
    .flash_miso_i(miso), .flash_sclk_o(sclk), .flash_mosi_o(mosi),
    .flash_cs_n_o(cs_n), .cfg_o(cfg), .logic_run_o(run),
    .fallback_active_o(fb), .init_lamp_o(lamp), .config_done_lamp_n_o(done_n),
    .ip_fixed_o(ipf), .ip_fixed_addr_o(ip_addr), .host_req_i(hreq),
    .host_reload_i(reload), .host_rsp_o(hrsp));
  fcl_flash_model fl0_i (.cs_n_i(cs_n[0]), .sclk_i(sclk), .mosi_i(mosi), .miso_o(m0));
  fcl_flash_model fl1_i (.cs_n_i(cs_n[1]), .sclk_i(sclk), .mosi_i(mosi), .miso_o(m1));

  // payload bytes are taken mid-cycle, while their one-cycle pulse stands
  always @(negedge clk_sys_i) if (cfg.valid === 1'b1) cfg_q.push_back(cfg.data);

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  function automatic logic [7:0] pl(input logic [7:0] seed, input int i);
    return seed + 8'(i) * 8'h11;
  endfunction : pl

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int k = 0; k < 8; k++) r = r[15] ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
    return r;
  endfunction : crc_step

  // image: 3 length bytes, payload, crc; bad spoils the crc low bit
  task automatic put_img(input int chip, input logic [23:0] base, input logic [7:0] seed,
                         input logic bad);
    logic [15:0] c;
    logic [7:0] b;
    c = CRC_INIT;
    for (int i = 0; i < PL_N + 5; i++) begin
      if (i < 3) b = (i == 2) ? 8'(PL_N) : 8'h00;
      else if (i < PL_N + 3) b = pl(seed, i - 3);
      else b = (i == PL_N + 3) ? c[15:8] : (c[7:0] ^ {7'h00, bad});
      if (i < PL_N + 3) c = crc_step(c, b);
      if (chip == 0) fl0_i.mem[int'(base + 24'(i))] = b;
      else fl1_i.mem[int'(base + 24'(i))] = b;
    end
  endtask : put_img

  task automatic do_reset(input logic c, input logic a, input logic ib);
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    cj <= c;
    aj <= a;
    ipb <= ib;
    repeat (11) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check("cs_in_reset", {30'h0, cs_n}, 32'h3);
    check("lamp_in_reset", {31'h0, done_n}, 32'h0);
    cfg_q.delete();
    @(posedge clk_sys_i);
    nrst_i <= 1'b1;
  endtask : do_reset

  // a good image of this size loads in about 900 cycles per attempt
  task automatic wait_run;
    int w;
    w = 0;
    while (run !== 1'b1 && w < 4000) begin
      @(negedge clk_sys_i);
      w++;
    end
    check("logic_run", {31'h0, run}, 32'h1);
  endtask : wait_run

  task automatic chk_cfg(input logic [7:0] seed);
    int b;
    b = cfg_q.size() - PL_N;
    check("cfg_count", 32'(b >= 0), 32'h1);
    for (int i = 0; i < PL_N; i++) begin
      if (b >= 0) check("cfg_byte", {24'h0, cfg_q[b + i]}, {24'h0, pl(seed, i)});
    end
  endtask : chk_cfg

  task automatic blinks(input int exp);
    int n;
    logic last;
    n = 0;
    last = lamp;
    repeat (204) begin
      @(negedge clk_sys_i);
      if (lamp !== last) n++;
      last = lamp;
    end
    check("lamp_toggles", 32'(n), 32'(exp));
  endtask : blinks

  task automatic host_xfer(input logic [7:0] tx, output logic [7:0] rx);
    int w;
    w = 0;
    while (hrsp.ready !== 1'b1 && w < 200) begin
      @(negedge clk_sys_i);
      w++;
    end
    @(posedge clk_sys_i);
    hreq.go <= 1'b1;
    hreq.tx <= tx;
    @(posedge clk_sys_i);
    hreq.go <= 1'b0;
    w = 0;
    do begin
      @(negedge clk_sys_i);
      w++;
    end while (hrsp.done !== 1'b1 && w < 80);
    check("host_done", {31'h0, hrsp.done}, 32'h1);
    rx = hrsp.rx;
  endtask : host_xfer

  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial begin
    logic [7:0] rx;
    nrst_i = 1'b0;
    cj = 1'b1;
    aj = 1'b1;
    ipa = 1'b1;
    ipb = 1'b0;
    reload = 1'b0;
    hreq = '0;
    // images only ever go to their own region, nothing in the data area
    put_img(0, USER_BASE, 8'h10, 1'b0);
    put_img(0, FALLBACK_BASE, 8'h80, 1'b0);
    put_img(1, USER_BASE, 8'h40, 1'b0);
    put_img(1, FALLBACK_BASE, 8'hc0, 1'b0);
    // good user image on the primary chip
    do_reset(1'b1, 1'b1, 1'b0);
    wait_run();
    check("fallback", {31'h0, fb}, 32'h0);
    check("done_lamp", {31'h0, done_n}, 32'h1);
    check("ip_fixed", {31'h0, ipf}, 32'h0);
    chk_cfg(8'h10);
    blinks(0);
    // host reads the first two payload bytes back through the spi path
    @(posedge clk_sys_i);
    hreq.cs <= 1'b1;
    host_xfer(READ_CMD, rx);
    host_xfer(USER_BASE[23:16], rx);
    host_xfer(8'h00, rx);
    host_xfer(8'h03, rx);
    host_xfer(8'h00, rx);
    check("host_rx0", {24'h0, rx}, {24'h0, pl(8'h10, 0)});
    host_xfer(8'h00, rx);
    check("host_rx1", {24'h0, rx}, {24'h0, pl(8'h10, 1)});
    @(posedge clk_sys_i);
    hreq.cs <= 1'b0;
    // corrupted user crc falls back and blinks
    put_img(0, USER_BASE, 8'h10, 1'b1);
    do_reset(1'b1, 1'b1, 1'b0);
    wait_run();
    wait_run();
    check("fallback", {31'h0, fb}, 32'h1);
    chk_cfg(8'h80);
    blinks(4);
    // repaired user image comes back on reload; straps still on the primary chip
    put_img(0, USER_BASE, 8'h10, 1'b0);
    @(posedge clk_sys_i);
    reload <= 1'b1;
    @(posedge clk_sys_i);
    reload <= 1'b0;
    repeat (20) @(negedge clk_sys_i);
    check("run_after_reload", {31'h0, run}, 32'h0);
    cfg_q.delete();
    wait_run();
    check("fallback", {31'h0, fb}, 32'h0);
    chk_cfg(8'h10);
    // both ip jumpers up force the fallback and the fixed address
    do_reset(1'b1, 1'b1, 1'b1);
    wait_run();
    check("fallback", {31'h0, fb}, 32'h1);
    check("ip_fixed", {31'h0, ipf}, 32'h1);
    check("ip_addr", ip_addr, FIXED_IP);
    chk_cfg(8'h80);
    // either chip jumper low boots the backup chip
    for (int j = 0; j < 2; j++) begin
      do_reset(j[0], ~j[0], 1'b0);
      wait_run();
      chk_cfg(8'h40);
    end
    // both images bad: nothing runs and the lamp stays lit
    put_img(0, USER_BASE, 8'h10, 1'b1);
    put_img(0, FALLBACK_BASE, 8'h80, 1'b1);
    do_reset(1'b1, 1'b1, 1'b0);
    repeat (3000) @(negedge clk_sys_i);
    check("run_failed", {31'h0, run}, 32'h0);
    check("done_lamp", {31'h0, done_n}, 32'h0);
    tally_and_finish();
  end

  // the whole sequence needs about 10000 cycles
  initial begin
    #(40 * 80000);
    n_fail++;
    tally_and_finish();
  end
endmodule : tb_top
